// *** design/mrst_alu.sv ***
// combinational operation unit: result, flags, write targets, skip decision
`timescale 1ns/100ps
module mrst_alu import mrst_pkg::*; (
  // operation and operands
  input wire mrst_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic [3:0] flags_in,
  input wire logic [15:0] prog_word,
  // results
  mrst_if.unit res
);
  logic [8:0] diff;
  logic [4:0] ldiff;
  logic [7:0] sub_b;
  logic bin;
  logic [7:0] r;
  logic [3:0] f;
  always_comb begin
    r = ZERO_BYTE;
    f = flags_in;
    res.wr_mem = 1'b0;
    res.wr_acc = 1'b0;
    res.skip = 1'b0;
    res.table_op = 1'b0;
    sub_b = (op == OP_SUB_IMM) ? imm : mem;
    bin = (op == OP_SBC || op == OP_SBC_MEM) ? ~flags_in[FLAG_C] : 1'b0;
    diff = {1'b0, acc} - {1'b0, sub_b} - {8'h00, bin};
    ldiff = {1'b0, acc[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, bin};
    case (op)
      OP_RL_ACC: begin
        r = {mem[6:0], mem[7]};
        res.wr_acc = 1'b1;
      end
      OP_RLC, OP_RLC_ACC: begin
        r = {mem[6:0], flags_in[FLAG_C]};
        f[FLAG_C] = mem[7];
        res.wr_mem = (op == OP_RLC);
        res.wr_acc = (op == OP_RLC_ACC);
      end
      OP_RR, OP_RR_ACC: begin
        r = {mem[0], mem[7:1]};
        res.wr_mem = (op == OP_RR);
        res.wr_acc = (op == OP_RR_ACC);
      end
      OP_RRC, OP_RRC_ACC: begin
        r = {flags_in[FLAG_C], mem[7:1]};
        f[FLAG_C] = mem[0];
        res.wr_mem = (op == OP_RRC);
        res.wr_acc = (op == OP_RRC_ACC);
      end
      OP_SBC, OP_SBC_MEM, OP_SUB, OP_SUB_IMM, OP_SUB_MEM: begin
        r = diff[7:0];
        f[FLAG_C] = ~diff[8];
        f[FLAG_AC] = ~ldiff[4];
        f[FLAG_OV] = (acc[7] != sub_b[7]) && (diff[7] != acc[7]);
        f[FLAG_Z] = (diff[7:0] == ZERO_BYTE);
        res.wr_mem = (op == OP_SBC_MEM || op == OP_SUB_MEM);
        res.wr_acc = ~res.wr_mem;
      end
      OP_DEC_SKIP, OP_DEC_SKIP_ACC: begin
        r = mem - ONE_BYTE;
        res.skip = (r == ZERO_BYTE);
        res.wr_mem = (op == OP_DEC_SKIP);
        res.wr_acc = (op == OP_DEC_SKIP_ACC);
      end
      OP_INC_SKIP, OP_INC_SKIP_ACC: begin
        r = mem + ONE_BYTE;
        res.skip = (r == ZERO_BYTE);
        res.wr_mem = (op == OP_INC_SKIP);
        res.wr_acc = (op == OP_INC_SKIP_ACC);
      end
      OP_SET_BYTE: begin
        r = SET_BYTE_VALUE;
        res.wr_mem = 1'b1;
      end
      OP_SET_BIT: begin
        r = mem | (ONE_BYTE << bit_sel);
        res.wr_mem = 1'b1;
      end
      OP_SKIP_BIT_SET: res.skip = mem[bit_sel];
      OP_SKIP_BIT_CLR: res.skip = ~mem[bit_sel];
      OP_SKIP_ZERO: res.skip = (mem == ZERO_BYTE);
      OP_COPY_SKIP: begin
        r = mem;
        res.wr_acc = 1'b1;
        res.skip = (mem == ZERO_BYTE);
      end
      OP_SWAP, OP_SWAP_ACC: begin
        r = {mem[3:0], mem[7:4]};
        res.wr_mem = (op == OP_SWAP);
        res.wr_acc = (op == OP_SWAP_ACC);
      end
      OP_TAB_CUR, OP_TAB_LAST: begin
        r = prog_word[7:0];
        res.wr_mem = 1'b1;
        res.table_op = 1'b1;
      end
      OP_XOR, OP_XOR_IMM, OP_XOR_MEM: begin
        r = acc ^ ((op == OP_XOR_IMM) ? imm : mem);
        f[FLAG_Z] = (r == ZERO_BYTE);
        res.wr_mem = (op == OP_XOR_MEM);
        res.wr_acc = ~res.wr_mem;
      end
      default: r = ZERO_BYTE;
    endcase
    res.result = r;
    res.flags = f;
  end
endmodule : mrst_alu

// *** design/mrst_core.sv ***
// execution datapath: sequencer, working register, flags, table fetch
`timescale 1ns/100ps
// Operation
// - rotate left through carry: carry into bit 0, bit 7 into carry, to memory.
// - accumulator form of that rotate writes working register, memory untouched.
// - rotate right, bit 0 into bit 7, to memory, no flags.
// - rotate right to working register, memory kept, no flags.
// - rotate right through carry, to memory or working register.
// - subtract with borrow: acc minus mem minus inverted carry; four flags.
// - carry cleared on negative result, set on zero or positive.
// - plain subtract of memory or immediate, to acc or memory, four flags.
// - decrement, skip next when zero, to memory or acc, no flags.
// - increment, skip next when wrapped to zero, no flags.
// - every conditional skip that is taken takes two machine cycles, one when not taken.
// - set byte loads FFH, flags unchanged.
// - set bit forces one bit to one, others kept.
// - skip when selected bit is one; no write, no flags.
// - skip when selected bit is zero; no write, no flags.
// - skip when whole byte is zero; no write, no flags.
// - copy byte to acc, skip when zero, no flags.
// - swap nibbles, to memory or acc, flags untouched.
// - table read current page: low byte to memory, high to table register.
// - table read last page: same, within the last program page.
// - exclusive-or with memory or immediate; only zero flag changes.
// - rotate left to acc, bit 7 into bit 0, memory and flags kept.
module mrst_core import mrst_pkg::*; #(
  parameter int PC_W = 14,
  parameter int TP_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // instruction issue
  input wire logic start,
  input wire mrst_op_t op,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic [PC_W-1:0] pc,
  input wire logic [TP_W-1:0] table_pointer,
  // program memory port
  output logic prog_rd,
  output logic [PC_W-1:0] prog_addr,
  input wire logic [15:0] prog_data,
  // data memory write port
  output logic mem_we,
  output logic [7:0] mem_wdata,
  // core state
  output logic [7:0] acc,
  output logic [3:0] flags,
  output logic [7:0] table_high_byte,
  output logic skip_next,
  output logic busy,
  output logic done
);
  // page bits must exist and the address must fit the program word port
  if (PC_W <= TP_W || PC_W > 16) begin : g_bad_width
    $error("mrst_core: PC_W must exceed TP_W and be <= 16");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_TABLE, ST_SKIP} mrst_state_t;

  typedef struct packed {
    mrst_state_t state;
    mrst_op_t op;
    logic [7:0] mem;
    logic [7:0] acc;
    logic [3:0] flags;
    logic [7:0] tbh;
    logic prog_rd;
    logic [PC_W-1:0] prog_addr;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic skip_next;
    logic busy;
    logic done;
  } mrst_regs_t;

  mrst_regs_t st_r;
  mrst_regs_t st_nxt;
  mrst_if res_i ();
  mrst_op_t alu_op;
  logic [7:0] alu_mem;

  // on a table fetch the unit sees the latched opcode; otherwise the live one
  assign alu_op = (st_r.state == ST_TABLE) ? st_r.op : op;
  assign alu_mem = (st_r.state == ST_TABLE) ? st_r.mem : mem_rdata;

  mrst_alu u_alu (
    .op(alu_op),
    .acc(st_r.acc),
    .mem(alu_mem),
    .imm(imm),
    .bit_sel(bit_sel),
    .flags_in(st_r.flags),
    .prog_word(prog_data),
    .res(res_i.unit)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.mem_we = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.prog_rd = 1'b0;
    case (st_r.state)
      ST_IDLE: begin
        st_nxt.skip_next = 1'b0;
        if (start) begin
          st_nxt.op = op;
          st_nxt.mem = mem_rdata;
          if (res_i.table_op) begin
            // page bits from pc, or all ones for the last page
            st_nxt.prog_rd = 1'b1;
            st_nxt.prog_addr = (op == OP_TAB_CUR) ?
              {pc[PC_W-1:TP_W], table_pointer} :
              {{(PC_W-TP_W){1'b1}}, table_pointer};
            st_nxt.busy = 1'b1;
            st_nxt.state = ST_TABLE;
          end else begin
            st_nxt.flags = res_i.flags;
            if (res_i.wr_acc) begin
              st_nxt.acc = res_i.result;
            end
            st_nxt.mem_we = res_i.wr_mem;
            st_nxt.mem_wdata = res_i.result;
            if (res_i.skip) begin
              // second cycle holds the dummy instruction
              st_nxt.busy = 1'b1;
              st_nxt.state = ST_SKIP;
            end else begin
              st_nxt.done = 1'b1;
            end
          end
        end
      end
      ST_TABLE: begin
        // program data sampled in the same cycle as the read strobe
        st_nxt.mem_we = res_i.wr_mem;
        st_nxt.mem_wdata = res_i.result;
        st_nxt.tbh = prog_data[15:8];
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.state = ST_IDLE;
      end
      ST_SKIP: begin
        st_nxt.skip_next = 1'b1;
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.state = ST_IDLE;
      end
      default: st_nxt.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '{state: ST_IDLE, op: OP_NONE, mem: ZERO_BYTE, acc: ACC_RESET,
                flags: FLAGS_RESET, tbh: TBH_RESET, prog_rd: 1'b0,
                prog_addr: '0, mem_we: 1'b0, mem_wdata: ZERO_BYTE,
                skip_next: 1'b0, busy: 1'b0, done: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prog_rd = st_r.prog_rd;
  assign prog_addr = st_r.prog_addr;
  assign mem_we = st_r.mem_we;
  assign mem_wdata = st_r.mem_wdata;
  assign acc = st_r.acc;
  assign flags = st_r.flags;
  assign table_high_byte = st_r.tbh;
  assign skip_next = st_r.skip_next;
  assign busy = st_r.busy;
  assign done = st_r.done;
endmodule : mrst_core

// *** design/mrst_if.sv ***
// interface: result bundle from the combinational unit to the sequencer
`timescale 1ns/100ps
interface mrst_if;
  logic [7:0] result;
  logic [3:0] flags;
  logic wr_mem;
  logic wr_acc;
  logic skip;
  logic table_op;
  modport unit (output result, flags, wr_mem, wr_acc, skip, table_op);
  modport seq (input result, flags, wr_mem, wr_acc, skip, table_op);
endinterface : mrst_if

// *** design/mrst_pkg.sv ***
// package: operation codes, flag positions, reset values and cycle counts
package mrst_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_RL_ACC, OP_RLC, OP_RLC_ACC, OP_RR, OP_RR_ACC, OP_RRC, OP_RRC_ACC,
    OP_SBC, OP_SBC_MEM, OP_SUB, OP_SUB_IMM, OP_SUB_MEM,
    OP_DEC_SKIP, OP_DEC_SKIP_ACC, OP_INC_SKIP, OP_INC_SKIP_ACC,
    OP_SET_BYTE, OP_SET_BIT, OP_SKIP_BIT_SET, OP_SKIP_BIT_CLR, OP_SKIP_ZERO, OP_COPY_SKIP,
    OP_SWAP, OP_SWAP_ACC, OP_TAB_CUR, OP_TAB_LAST, OP_XOR, OP_XOR_IMM, OP_XOR_MEM
  } mrst_op_t;
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [7:0] TBH_RESET = 8'h00;
  localparam logic [7:0] SET_BYTE_VALUE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam int SKIP_CYCLES = 2;
endpackage : mrst_pkg

// *** testbench/mrst_core_properties.sv ***
// checker: port-level relations of the execution datapath
`timescale 1ns/100ps
module mrst_core_chk import mrst_pkg::*; (
  // clock, reset and issue
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire mrst_op_t op,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] prog_data,
  // results
  input wire logic prog_rd,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] acc,
  input wire logic [3:0] flags,
  input wire logic [7:0] table_high_byte,
  input wire logic skip_next,
  input wire logic busy,
  input wire logic done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // operands are sampled on a taking edge, so every antecedent but a_table_pair's (prog_rd) starts there
  a_set_byte_val: assert property (
    start && !busy && op == OP_SET_BYTE |=> mem_we && mem_wdata == SET_BYTE_VALUE)
    else $error("set byte wrote a wrong value");
  a_rr_no_flags: assert property (
    start && !busy && op == OP_RR |=> $stable(flags) && mem_we
    && mem_wdata == (($past(mem_rdata) >> 1) | ($past(mem_rdata) << 7)))
    else $error("rotate right result or flags wrong");
  a_rl_acc_val: assert property (
    start && !busy && op == OP_RL_ACC |=> !mem_we
    && acc == (($past(mem_rdata) << 1) | ($past(mem_rdata) >> 7)))
    else $error("rotate left to acc wrong");
  a_swap_nibbles: assert property (
    start && !busy && op == OP_SWAP |=> mem_we
    && mem_wdata == (($past(mem_rdata) << 4) | ($past(mem_rdata) >> 4)))
    else $error("nibble swap wrong");
  a_skip_two_cycles: assert property (
    start && !busy && op == OP_SKIP_ZERO && mem_rdata == ZERO_BYTE
    |=> busy && !done ##1 !busy && skip_next && done)
    else $error("zero skip timing wrong");
  a_sub_carry: assert property (
    start && !busy && op == OP_SUB |=> flags[FLAG_C] == ($past(acc) >= $past(mem_rdata)))
    else $error("subtract carry wrong");
  a_xor_zero: assert property (
    start && !busy && op == OP_XOR |=> flags[FLAG_Z] == (($past(acc) ^ $past(mem_rdata)) == 0))
    else $error("xor zero flag wrong");
  a_table_pair: assert property (
    prog_rd |=> done && mem_we && mem_wdata == $past(prog_data[7:0])
    && table_high_byte == $past(prog_data[15:8]))
    else $error("table word split wrong");
  c_skip: cover property (skip_next && done);
  c_table: cover property (prog_rd ##1 done);
  c_sbc_mem: cover property (start && !busy && op == OP_SBC_MEM);
endmodule : mrst_core_chk

bind mrst_core mrst_core_chk u_chk (.mclk, .reset, .start, .op, .mem_rdata, .prog_data,
  .prog_rd, .mem_we, .mem_wdata, .acc, .flags, .table_high_byte, .skip_next, .busy, .done);

// *** testbench/tb.sv ***
// testbench: directed scenarios for the execution datapath
`timescale 1ns/100ps
module tb import mrst_pkg::*; ;
  logic mclk, reset, start, prog_rd, mem_we, skip_next, busy, done, got_we, got_skip;
  mrst_op_t op;
  logic [7:0] mem_rdata, imm, table_pointer, mem_wdata, acc, table_high_byte, got_wd;
  logic [2:0] bit_sel;
  logic [13:0] pc, prog_addr;
  logic [15:0] prog_data;
  logic [3:0] flags;
  int num_errors, comparisons, ncyc, cycles;

  mrst_core dut (.mclk, .reset, .start, .op, .mem_rdata, .imm, .bit_sel, .pc, .table_pointer,
    .prog_rd, .prog_addr, .prog_data, .mem_we, .mem_wdata, .acc, .flags, .table_high_byte,
    .skip_next, .busy, .done);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // about forty ops of at most five cycles; generous ceiling
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // imm follows the memory byte; pulses are caught on whichever cycle they land
  task automatic run(mrst_op_t o, logic [7:0] m, logic [2:0] b);
    @(posedge mclk);
    start <= 1'b1;
    op <= o;
    mem_rdata <= m;
    imm <= m;
    bit_sel <= b;
    @(posedge mclk);
    start <= 1'b0;
    got_we = 1'b0;
    got_skip = 1'b0;
    for (ncyc = 1; ncyc < 6; ncyc++) begin
      #1;
      if (mem_we === 1'b1) begin
        got_we = 1'b1;
        got_wd = mem_wdata;
      end
      if (skip_next === 1'b1) got_skip = 1'b1;
      if (done === 1'b1) break;
      @(posedge mclk);
    end
  endtask : run

  // dest: 0 no write, 1 memory, 2 working register
  task automatic do_op(mrst_op_t o, logic [7:0] m, int b, int sk, int dest, logic [7:0] val,
      logic [3:0] fl);
    run(o, m, b[2:0]);
    chk(16'(got_skip), 16'(sk));
    chk(16'(ncyc), (sk == 1) ? 16'(SKIP_CYCLES) : 16'h0001);
    chk(16'(got_we), 16'(dest == 1));
    if (dest == 1) chk(16'(got_wd), 16'(val));
    if (dest == 2) chk(16'(acc), 16'(val));
    chk(16'(flags), 16'(fl));
  endtask : do_op

  task automatic tab(mrst_op_t o, logic [15:0] w, logic [13:0] a);
    @(posedge mclk);
    prog_data <= w;
    run(o, 8'h00, 3'h0);
    chk(16'(got_we), 16'h0001);
    chk(16'(got_wd), 16'(w[7:0]));
    chk(16'(table_high_byte), 16'(w[15:8]));
    chk(16'(prog_addr), 16'(a));
    chk(16'(ncyc), 16'h0002);
    chk(16'(flags), 16'h0005);
  endtask : tab

  task automatic t_rotate();
    do_op(OP_COPY_SKIP, 8'h81, 0, 0, 2, 8'h81, 4'h0);
    do_op(OP_SUB_IMM, 8'h82, 0, 0, 2, 8'hFF, 4'h0);
    do_op(OP_RLC, 8'h81, 0, 0, 1, 8'h02, 4'h1);
    do_op(OP_RLC_ACC, 8'h40, 0, 0, 2, 8'h81, 4'h0);
    do_op(OP_RRC, 8'h01, 0, 0, 1, 8'h00, 4'h1);
    do_op(OP_RRC_ACC, 8'h02, 0, 0, 2, 8'h81, 4'h0);
    do_op(OP_RR, 8'h01, 0, 0, 1, 8'h80, 4'h0);
    do_op(OP_RR_ACC, 8'h02, 0, 0, 2, 8'h01, 4'h0);
    do_op(OP_RL_ACC, 8'hC0, 0, 0, 2, 8'h81, 4'h0);
  endtask : t_rotate

  task automatic t_arith();
    do_op(OP_COPY_SKIP, 8'h50, 0, 0, 2, 8'h50, 4'h0);
    do_op(OP_SUB, 8'h50, 0, 0, 2, 8'h00, 4'h7);
    do_op(OP_COPY_SKIP, 8'h80, 0, 0, 2, 8'h80, 4'h7);
    do_op(OP_SUB_IMM, 8'h01, 0, 0, 2, 8'h7F, 4'h9);
    do_op(OP_SBC, 8'h00, 0, 0, 2, 8'h7F, 4'h3);
    do_op(OP_SUB_MEM, 8'hFF, 0, 0, 1, 8'h80, 4'hA);
    do_op(OP_SBC_MEM, 8'h0F, 0, 0, 1, 8'h6F, 4'h1);
    do_op(OP_XOR, 8'h7F, 0, 0, 2, 8'h00, 4'h5);
    do_op(OP_XOR_IMM, 8'hA5, 0, 0, 2, 8'hA5, 4'h1);
    do_op(OP_XOR_MEM, 8'hA5, 0, 0, 1, 8'h00, 4'h5);
  endtask : t_arith

  task automatic t_skip_set();
    do_op(OP_DEC_SKIP, 8'h01, 0, 1, 1, 8'h00, 4'h5);
    do_op(OP_DEC_SKIP, 8'h02, 0, 0, 1, 8'h01, 4'h5);
    do_op(OP_DEC_SKIP_ACC, 8'h00, 0, 0, 2, 8'hFF, 4'h5);
    do_op(OP_INC_SKIP, 8'hFF, 0, 1, 1, 8'h00, 4'h5);
    do_op(OP_INC_SKIP_ACC, 8'hFF, 0, 1, 2, 8'h00, 4'h5);
    do_op(OP_SKIP_BIT_SET, 8'h08, 3, 1, 0, 8'h00, 4'h5);
    do_op(OP_SKIP_BIT_SET, 8'h08, 2, 0, 0, 8'h00, 4'h5);
    do_op(OP_SKIP_BIT_CLR, 8'h08, 3, 0, 0, 8'h00, 4'h5);
    do_op(OP_SKIP_BIT_CLR, 8'h08, 7, 1, 0, 8'h00, 4'h5);
    do_op(OP_SKIP_ZERO, 8'h00, 0, 1, 0, 8'h00, 4'h5);
    do_op(OP_SKIP_ZERO, 8'h10, 0, 0, 0, 8'h00, 4'h5);
    do_op(OP_COPY_SKIP, 8'h00, 0, 1, 2, 8'h00, 4'h5);
    do_op(OP_SET_BYTE, 8'h12, 0, 0, 1, 8'hFF, 4'h5);
    do_op(OP_SET_BIT, 8'h12, 7, 0, 1, 8'h92, 4'h5);
    do_op(OP_SWAP, 8'h12, 0, 0, 1, 8'h21, 4'h5);
    do_op(OP_SWAP_ACC, 8'h3C, 0, 0, 2, 8'hC3, 4'h5);
    tab(OP_TAB_CUR, 16'h3CC3, 14'h1256);
    tab(OP_TAB_LAST, 16'h5AA5, 14'h3F56);
  endtask : t_skip_set

  initial begin
    reset = 1'b1;
    start = 1'b0;
    op = OP_NONE;
    mem_rdata = 8'h00;
    imm = 8'h00;
    bit_sel = 3'h0;
    pc = 14'h1234;
    table_pointer = 8'h56;
    prog_data = 16'h0000;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_rotate();
    t_arith();
    t_skip_set();
    stop_test();
  end
endmodule : tb
